/* File: bench/serial_master.sv */
// master model for the serial memory: drives clock, select, reset request and data
// assumes the bench ands o_sda with the device pull to make the open-drain wire level
`timescale 1ns/1ps
module serial_master (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_scl = 1'b1,
    output logic o_sda = 1'b1,
    output logic o_cs_n = 1'b1,
    output logic o_rst_req = 1'b0
);
    // pins move just after a system edge; the serial clock stands still between calls
    task automatic drv(input logic c, input logic dat, input int n);
        o_scl = c;
        o_sda = dat;
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    task automatic pins(input logic cs_n, input logic rst);
        o_cs_n = cs_n;
        o_rst_req = rst;
        repeat (4) @(posedge i_clk);
        #2;
    endtask
    // low for 5 clocks, high for 3: device output has settled well before the rise
    task automatic bit_io(input logic b, output logic r);
        drv(1'b0, o_sda, 4);
        drv(1'b0, b, 1);
        drv(1'b1, b, 2);
        r = i_line;
        drv(1'b1, b, 1);
    endtask
    // start is cond(1, 0), stop is cond(0, 1)
    task automatic cond(input logic first, input logic last);
        drv(1'b0, o_sda, 4);
        drv(1'b0, first, 1);
        drv(1'b1, first, 4);
        drv(1'b1, last, 4);
    endtask
    task automatic xfer(input logic [7:0] dat, input logic last, output logic [7:0] got, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(dat[i], got[i]);
        bit_io(last, r);
        ack = ~r;
    endtask
endmodule

/* File: bench/test_password_serial_memory_protocol.sv */
// self-checking bench for the password-protected serial memory protocol
// assumes the master model owns every serial pin; the data wire has a pull-up
`timescale 1ns/1ps
module test_password_serial_memory_protocol;
    localparam logic [31:0] PAT = 32'h5a3c_0f96; // arbitrary answer pattern
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic scl, m_sda, cs_n, rst_req, sda_o, sda_oe, nv_busy, a;
    logic [7:0] d, q;
    logic [7:0] mem [112] = '{default: 8'h00};
    logic [63:0] key;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    wire sda_line = m_sda & (sda_oe ? sda_o : 1'b1);
    serial_master m (.i_clk(i_sys_clk), .i_line(sda_line), .o_scl(scl), .o_sda(m_sda), .o_cs_n(cs_n),
        .o_rst_req(rst_req));
    password_serial_memory_protocol #(.NV_WRITE_CYCLES(400), .ATR_PATTERN(PAT)) uut (.i_sys_clk(i_sys_clk),
        .i_reset(i_reset), .i_scl(scl), .i_sda(sda_line), .i_cs_n(cs_n), .i_rst_req(rst_req),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_nv_busy(nv_busy));
    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 2000 && nv_busy !== 1'b0; n++) begin
            @(posedge i_sys_clk);
            #2;
        end
        chk(nv_busy, 1'b0);
    endtask
    task automatic close();
        m.cond(1'b0, 1'b1);
        m.pins(1'b1, 1'b0);
    endtask
    // command, password, one poll while busy, then the poll that decides access
    task automatic auth(input logic [7:0] cmd, input logic [63:0] pw, input logic ok);
        m.pins(1'b0, 1'b0);
        m.cond(1'b1, 1'b0);
        m.xfer(cmd, 1'b1, q, a);
        chk(a, 1'b1);
        for (int i = 7; i >= 0; i--) m.xfer(pw[8*i +: 8], 1'b1, q, a);
        chk(nv_busy, 1'b1);
        m.cond(1'b1, 1'b0);
        m.xfer(8'h55, 1'b1, q, a);
        chk(a, 1'b0);
        wait_idle();
        m.cond(1'b1, 1'b0);
        m.xfer(8'h55, 1'b1, q, a);
        chk(a, ok);
    endtask
    initial begin
        logic [7:0] ill [3] = '{8'h00, 8'h9c, 8'h9f};
        void'($urandom(82249));
        repeat (5) @(posedge i_sys_clk);
        #2;
        i_reset = 1'b0;
        chk({sda_oe, nv_busy}, 8'h00);
        // a full write to the last sector, then an over-long and a short one that must not land
        for (int k = 0; k < 3; k++) begin
            int n;
            n = (k == 2) ? 7 : 8 + k;
            auth(8'h9a, 64'h0, 1'b1);
            for (int i = 0; i < n; i++) begin
                d = 8'($urandom);
                m.xfer(d, 1'b1, q, a);
                chk(a, 1'b1);
                if (n == 8)
                    mem[104 + i] = d;
            end
            close();
            wait_idle();
        end
        key = {$urandom, $urandom} | 64'h1;
        auth(8'hfc, 64'h0, 1'b1);
        for (int i = 7; i >= 0; i--) m.xfer(key[8*i +: 8], 1'b1, q, a);
        close();
        wait_idle();
        auth(8'h9a, key, 1'b1);
        // a start mid-data drops the write; a stop mid-password cancels it, then the zero password is refused
        for (int i = 0; i < 3; i++) m.xfer(8'ha5, 1'b1, q, a);
        m.cond(1'b1, 1'b0);
        m.xfer(8'h9a, 1'b1, q, a);
        chk(a, 1'b1);
        m.xfer(8'h00, 1'b1, q, a);
        close();
        chk(nv_busy, 1'b0);
        auth(8'h9a, 64'h0, 1'b0);
        close();
        // read password changed under the write password, then used for the read
        auth(8'hfe, key, 1'b1);
        for (int i = 7; i >= 0; i--) m.xfer(~key[8*i +: 8], 1'b1, q, a);
        close();
        wait_idle();
        auth(8'h9b, ~key, 1'b1);
        for (int i = 0; i < 10; i++) begin
            m.xfer(8'hff, i == 9, d, a);
            chk(d, mem[(104 + i) % 112]);
        end
        close();
        for (int j = 0; j < 3; j++) begin
            m.pins(1'b0, 1'b0);
            m.cond(1'b1, 1'b0);
            m.xfer(ill[j], 1'b1, q, a);
            chk(a, 1'b0);
            close();
        end
        // clock parked low first so the first sample sees bit zero
        m.pins(1'b0, 1'b0);
        m.drv(1'b0, 1'b1, 4);
        m.pins(1'b0, 1'b1);
        m.pins(1'b0, 1'b0);
        for (int i = 0; i < 40; i++) begin
            m.bit_io(1'b1, a);
            chk(a, PAT[i % 32]);
        end
        m.pins(1'b1, 1'b0);
        chk(sda_oe, 1'b0);
        wrap_up();
    end
endmodule

/* File: rtl/password_serial_memory_protocol.sv */
// serial slave, command engine and array of the password-protected memory
// assumes the bench resolves the open-drain data wire from o_sda_oe
// Operation
// - data line is open drain; driven only while sending bits or acknowledges.
// - select high releases data line and returns to standby; writes continue.
// - reset pulse with select low and no write starts 32-bit answer stream.
// - select high during answer stream aborts it into standby.
// - fourteen sectors of eight bytes; accesses start at byte zero of sector.
// - reads continue as long as master keeps clocking and acknowledging.
// - both passwords start as all zeros.
// - data moves only after accepted password and completed poll.
// - eight-bit units; receiver pulls line low in ninth clock to acknowledge.
// - command byte during nonvolatile write gets no acknowledge.
// - stop before nonvolatile write cancels pending write and enters standby.
// - standby after each transaction and after failed protected access.
// - master supplies clock; device is slave and never drives clock.
// - data line changes only while clock low; high changes mean start/stop.
// - start is data falling with clock high; input ignored until start.
// - start during command or write data restarts; ignored while outputting.
// - stop is data rising with clock high; ends input, ignored during output.
// - sector command is 100, four sector bits, then 0 write or 1 read.
// - 11111100 changes write password, 01010101 polls; password checks per command.
// - unknown command byte gets no acknowledge and device returns to standby.
// - exactly eight data bytes then stop commit a write; otherwise unchanged.
// - poll after password acknowledges only if password was correct.
// - continuous reads advance through sectors, wrapping last to first.
// - answer stream repeats its 32 bits while clocks continue.
`timescale 1ns/1ps

module password_serial_memory_protocol #(
    parameter int unsigned NV_WRITE_CYCLES = pwmem_pkg::NV_WRITE_CYCLES,
    parameter logic [31:0] ATR_PATTERN = pwmem_pkg::ATR_PATTERN_DEFAULT
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_cs_n,
    input wire logic i_rst_req,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_nv_busy
);

    localparam logic [pwmem_pkg::BUSY_W-1:0] BUSY_LOAD = pwmem_pkg::BUSY_W'(NV_WRITE_CYCLES);

    pwmem_pkg::core_state_t st;
    pwmem_pkg::core_state_t next_st;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic cs_high;
    logic rst_rise;
    logic busy;
    logic byte_done;
    logic [7:0] rx_byte;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] pwd_byte(input logic [63:0] pw, input logic [3:0] idx);
        logic [5:0] base;
        base = 6'(6'd63 - {idx[2:0], 3'b000});
        return pw[base -: 8];
    endfunction

    function automatic logic [pwmem_pkg::ADDR_W-1:0] next_addr(input logic [pwmem_pkg::ADDR_W-1:0] a);
        return (a == pwmem_pkg::LAST_ADDR) ? '0 : pwmem_pkg::ADDR_W'(a + 1'b1);
    endfunction

    // ----------------------------------------
    // pin edges, from second synchroniser stage onward only
    // ----------------------------------------
    assign scl_rise = st.scl_s[1] & ~st.scl_s[2];
    assign scl_fall = ~st.scl_s[1] & st.scl_s[2];
    assign start_seen = st.scl_s[1] & st.scl_s[2] & ~st.sda_s[1] & st.sda_s[2];
    assign stop_seen = st.scl_s[1] & st.scl_s[2] & st.sda_s[1] & ~st.sda_s[2];
    assign cs_high = st.cs_s[1];
    assign rst_rise = st.rst_s[1] & ~st.rst_s[2];
    assign busy = (st.busy_cnt != '0);
    assign byte_done = scl_rise && (st.cnt == pwmem_pkg::BYTE_LAST) && (st.state != pwmem_pkg::ST_RDATA);
    assign rx_byte = {st.sh[6:0], st.sda_s[1]};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [63:0] ref_pw;
        logic [pwmem_pkg::ADDR_W-1:0] base;
        logic [7:0] tx;
        next_st = st;
        ref_pw = (st.op == pwmem_pkg::OP_READ) ? st.rpw : st.wpw;
        base = {st.sector[3:0], 3'b000};
        tx = st.mem[st.addr];
        next_st.scl_s = {st.scl_s[1:0], i_scl};
        next_st.sda_s = {st.sda_s[1:0], i_sda};
        next_st.cs_s = {st.cs_s[1:0], i_cs_n};
        next_st.rst_s = {st.rst_s[1:0], i_rst_req};
        if (busy) begin
            next_st.busy_cnt = pwmem_pkg::BUSY_W'(st.busy_cnt - 1'b1);
        end
        if (cs_high) begin
            // deselect leaves a running nonvolatile cycle alone
            next_st.state = pwmem_pkg::ST_IDLE;
            next_st.after = pwmem_pkg::ST_IDLE;
            next_st.oe = 1'b0;
            next_st.cnt = '0;
            next_st.op = pwmem_pkg::OP_NONE;
            next_st.pwd_ok = 1'b0;
        end else if (rst_rise && st.state == pwmem_pkg::ST_ATR) begin
            // a second pulse mid-stream stops it with the line released
            next_st.state = pwmem_pkg::ST_IDLE;
            next_st.oe = 1'b0;
        end else if (rst_rise && !busy) begin
            next_st.state = pwmem_pkg::ST_ATR;
            next_st.atr_idx = '0;
            next_st.oe = ~ATR_PATTERN[0];
            next_st.op = pwmem_pkg::OP_NONE;
        end else if (st.state == pwmem_pkg::ST_ATR) begin
            if (scl_fall) begin
                next_st.atr_idx = 5'(st.atr_idx + 1'b1);
                next_st.oe = ~ATR_PATTERN[5'(st.atr_idx + 1'b1)];
            end
        end else if (start_seen && st.state != pwmem_pkg::ST_RDATA) begin
            next_st.state = pwmem_pkg::ST_CMD;
            next_st.after = pwmem_pkg::ST_CMD;
            next_st.cnt = '0;
            next_st.oe = 1'b0;
            next_st.ack = 1'b0;
            if (st.state != pwmem_pkg::ST_IDLE) begin
                next_st.op = pwmem_pkg::OP_NONE;
            end
        end else if (stop_seen && st.state != pwmem_pkg::ST_RDATA) begin
            next_st.state = pwmem_pkg::ST_IDLE;
            next_st.after = pwmem_pkg::ST_IDLE;
            next_st.oe = 1'b0;
            next_st.cnt = '0;
            if (st.state == pwmem_pkg::ST_WDATA) begin
                next_st.op = pwmem_pkg::OP_NONE;
                if (st.bytes == pwmem_pkg::BYTE_FULL && !st.over) begin
                    next_st.busy_cnt = BUSY_LOAD;
                    unique case (st.op)
                        pwmem_pkg::OP_CHG_WPW: next_st.wpw = st.wbuf;
                        pwmem_pkg::OP_CHG_RPW: next_st.rpw = st.wbuf;
                        default: begin
                            for (int i = 0; i < pwmem_pkg::SECTOR_BYTES; i++) begin
                                next_st.mem[pwmem_pkg::ADDR_W'(base + i)] = st.wbuf[63 - 8 * i -: 8];
                            end
                        end
                    endcase
                end
            end else if (st.state != pwmem_pkg::ST_IDLE) begin
                next_st.op = pwmem_pkg::OP_NONE;
            end
        end else if (scl_rise) begin
            if (st.cnt < pwmem_pkg::BYTE_FULL) begin
                next_st.cnt = 4'(st.cnt + 1'b1);
                if (st.state != pwmem_pkg::ST_RDATA) begin
                    next_st.sh = rx_byte;
                end
            end else if (st.cnt == pwmem_pkg::BYTE_FULL) begin
                next_st.cnt = 4'h9;
                if (st.state == pwmem_pkg::ST_RDATA) begin
                    // master acknowledge keeps the stream going
                    next_st.after = st.sda_s[1] ? pwmem_pkg::ST_IDLE : pwmem_pkg::ST_RDATA;
                end
            end
            if (byte_done) begin
                next_st.ack = 1'b0;
                next_st.after = pwmem_pkg::ST_IDLE;
                unique case (st.state)
                    pwmem_pkg::ST_CMD: begin
                        if (busy) begin
                            next_st.ack = 1'b0;
                        end else if (rx_byte == pwmem_pkg::CMD_PWD_POLL) begin
                            if (st.op == pwmem_pkg::OP_NONE) begin
                                next_st.ack = 1'b1;
                            end else if (st.pwd_ok) begin
                                next_st.ack = 1'b1;
                                next_st.after = (st.op == pwmem_pkg::OP_READ) ? pwmem_pkg::ST_RDATA
                                                                             : pwmem_pkg::ST_WDATA;
                                next_st.addr = base;
                                next_st.bytes = '0;
                                next_st.over = 1'b0;
                            end else begin
                                next_st.op = pwmem_pkg::OP_NONE;
                            end
                        end else if ((rx_byte & pwmem_pkg::CMD_SECTOR_MASK) == pwmem_pkg::CMD_SECTOR_CODE) begin
                            if (rx_byte[pwmem_pkg::CMD_SECTOR_LSB +: 4] >= pwmem_pkg::SECTOR_LIMIT) begin
                                next_st.op = pwmem_pkg::OP_NONE;
                            end else begin
                                next_st.ack = 1'b1;
                                next_st.after = pwmem_pkg::ST_PWD;
                                next_st.sector = rx_byte[pwmem_pkg::CMD_SECTOR_LSB +: 4];
                                next_st.op = rx_byte[pwmem_pkg::CMD_RW_BIT] ? pwmem_pkg::OP_READ
                                                                            : pwmem_pkg::OP_WRITE;
                                next_st.bytes = '0;
                                next_st.mism = 1'b0;
                                next_st.pwd_ok = 1'b0;
                            end
                        end else if (rx_byte == pwmem_pkg::CMD_CHG_WRITE_PWD
                                     || rx_byte == pwmem_pkg::CMD_CHG_READ_PWD) begin
                            next_st.ack = 1'b1;
                            next_st.after = pwmem_pkg::ST_PWD;
                            next_st.op = (rx_byte == pwmem_pkg::CMD_CHG_WRITE_PWD) ? pwmem_pkg::OP_CHG_WPW
                                                                                   : pwmem_pkg::OP_CHG_RPW;
                            next_st.bytes = '0;
                            next_st.mism = 1'b0;
                            next_st.pwd_ok = 1'b0;
                        end else begin
                            next_st.op = pwmem_pkg::OP_NONE;
                        end
                    end
                    pwmem_pkg::ST_PWD: begin
                        // verdict waits for the last byte so timing leaks nothing
                        next_st.ack = 1'b1;
                        next_st.mism = st.mism | (rx_byte != pwd_byte(ref_pw, st.bytes));
                        next_st.bytes = 4'(st.bytes + 1'b1);
                        next_st.after = pwmem_pkg::ST_PWD;
                        if (st.bytes == pwmem_pkg::BYTE_LAST) begin
                            next_st.pwd_ok = ~(st.mism | (rx_byte != pwd_byte(ref_pw, st.bytes)));
                            next_st.busy_cnt = BUSY_LOAD;
                            next_st.after = pwmem_pkg::ST_IDLE;
                        end
                    end
                    pwmem_pkg::ST_WDATA: begin
                        next_st.ack = 1'b1;
                        next_st.after = pwmem_pkg::ST_WDATA;
                        if (st.bytes < pwmem_pkg::BYTE_FULL) begin
                            next_st.wbuf = {st.wbuf[55:0], rx_byte};
                            next_st.bytes = 4'(st.bytes + 1'b1);
                        end else begin
                            next_st.over = 1'b1;
                        end
                    end
                    default: begin
                        next_st.ack = 1'b0;
                    end
                endcase
            end
        end else if (scl_fall) begin
            if (st.cnt == pwmem_pkg::BYTE_FULL) begin
                // receiver owns the ninth clock
                next_st.oe = (st.state == pwmem_pkg::ST_RDATA) ? 1'b0 : st.ack;
            end else if (st.cnt == 4'h9) begin
                next_st.cnt = '0;
                next_st.state = st.after;
                next_st.oe = 1'b0;
                if (st.after == pwmem_pkg::ST_RDATA) begin
                    next_st.sh = tx;
                    next_st.oe = ~tx[7];
                    next_st.addr = next_addr(st.addr);
                end
            end else if (st.state == pwmem_pkg::ST_RDATA && st.cnt != '0) begin
                next_st.sh = {st.sh[6:0], 1'b0};
                next_st.oe = ~st.sh[6];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0;
            // sync stages start at the idle pin levels so no false edge follows reset
            st.scl_s <= 3'h7;
            st.sda_s <= 3'h7;
            st.cs_s <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // pins: only ever pull low, clock is input only
    // ----------------------------------------
    assign o_sda_o = 1'b0;
    assign o_sda_oe = st.oe;
    assign o_nv_busy = busy;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    a_deselect_release: assert property (cs_high |=> !o_sda_oe)
        else $error("data line driven while deselected");
    a_atr_abort: assert property (st.state == pwmem_pkg::ST_ATR && cs_high |=> st.state == pwmem_pkg::ST_IDLE)
        else $error("answer stream not aborted by deselect");
    a_atr_entry: assert property (rst_rise && !cs_high && !busy && st.state != pwmem_pkg::ST_ATR
                                  |=> st.state == pwmem_pkg::ST_ATR && st.atr_idx == 5'h00)
        else $error("answer stream did not start");
    a_atr_blocked: assert property (busy && st.state != pwmem_pkg::ST_ATR |=> st.state != pwmem_pkg::ST_ATR)
        else $error("answer stream started during write");
    a_busy_nack: assert property (byte_done && st.state == pwmem_pkg::ST_CMD && busy && !cs_high
                                  |=> !st.ack ##1 (!o_sda_oe)[*2])
        else $error("command acknowledged while busy");
    a_illegal_sector: assert property (byte_done && st.state == pwmem_pkg::ST_CMD && !busy && !cs_high
                                       && (rx_byte & pwmem_pkg::CMD_SECTOR_MASK) == pwmem_pkg::CMD_SECTOR_CODE
                                       && rx_byte[4:1] >= pwmem_pkg::SECTOR_LIMIT
                                       |=> !st.ack && st.after == pwmem_pkg::ST_IDLE)
        else $error("illegal sector accepted");
    a_stop_cancel: assert property (stop_seen && !cs_high && !rst_rise
                                    && (st.state == pwmem_pkg::ST_CMD || st.state == pwmem_pkg::ST_PWD)
                                    |=> st.state == pwmem_pkg::ST_IDLE && st.op == pwmem_pkg::OP_NONE)
        else $error("stop did not cancel input");
    a_short_write: assert property (stop_seen && !cs_high && !rst_rise && st.state == pwmem_pkg::ST_WDATA
                                    && st.bytes != pwmem_pkg::BYTE_FULL |=> st.mem == $past(st.mem))
        else $error("sector changed by short write");
    a_start_restart: assert property (start_seen && !cs_high && !rst_rise
                                      && (st.state == pwmem_pkg::ST_PWD || st.state == pwmem_pkg::ST_WDATA)
                                      |=> st.state == pwmem_pkg::ST_CMD && st.cnt == 4'h0)
        else $error("start did not restart command input");
    a_read_wrap: assert property (scl_fall && st.cnt == 4'h9 && st.after == pwmem_pkg::ST_RDATA && !cs_high
                                  && !rst_rise && st.addr == pwmem_pkg::LAST_ADDR |=> st.addr == '0)
        else $error("read address did not wrap");
    a_tx_low_clock: assert property (st.state == pwmem_pkg::ST_RDATA && $past(st.state) == pwmem_pkg::ST_RDATA
                                     && $changed(st.oe) |-> !st.scl_s[2])
        else $error("data changed while clock high");
    a_pwd_zero: assert property ($past(st.busy_cnt) == '0 && st.busy_cnt == '0 |-> st.wpw == $past(st.wpw))
        else $error("password changed without write cycle");
    a_unknown_nack: assert property (byte_done && st.state == pwmem_pkg::ST_CMD && !busy && !cs_high && !rst_rise
                                     && rx_byte != pwmem_pkg::CMD_PWD_POLL
                                     && rx_byte != pwmem_pkg::CMD_CHG_WRITE_PWD
                                     && rx_byte != pwmem_pkg::CMD_CHG_READ_PWD
                                     && (rx_byte & pwmem_pkg::CMD_SECTOR_MASK) != pwmem_pkg::CMD_SECTOR_CODE
                                     |=> !st.ack && st.after == pwmem_pkg::ST_IDLE)
        else $error("unknown command acknowledged");
    a_bad_pwd_nack: assert property (byte_done && st.state == pwmem_pkg::ST_CMD && !busy && !cs_high && !rst_rise
                                     && rx_byte == pwmem_pkg::CMD_PWD_POLL
                                     && st.op != pwmem_pkg::OP_NONE && !st.pwd_ok
                                     |=> !st.ack && st.op == pwmem_pkg::OP_NONE)
        else $error("poll acknowledged after wrong password");

    c_atr_run: cover property (st.state == pwmem_pkg::ST_ATR && st.atr_idx == 5'h1f ##1 st.atr_idx == 5'h00);
    c_read_stream: cover property (st.state == pwmem_pkg::ST_RDATA && st.after == pwmem_pkg::ST_RDATA);
    c_commit: cover property (stop_seen && st.state == pwmem_pkg::ST_WDATA && st.bytes == pwmem_pkg::BYTE_FULL);
    c_bad_pwd: cover property (byte_done && st.state == pwmem_pkg::ST_CMD && rx_byte == pwmem_pkg::CMD_PWD_POLL
                               && st.op != pwmem_pkg::OP_NONE && !st.pwd_ok && !busy);

endmodule

/* File: shared/pwmem_pkg.sv */
// constants, types and state layout for the password-protected serial memory
// assumes a 50 MHz system clock that samples all serial pins
package pwmem_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int NV_WRITE_TIME_US = 10_000;
    localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000);
    localparam int BUSY_W = 20;

    // ----------------------------------------
    // array geometry
    // ----------------------------------------
    localparam int SECTORS = 14;
    localparam int SECTOR_BYTES = 8;
    localparam int ARRAY_BYTES = 112;
    localparam int ADDR_W = 7;
    localparam int PWD_BYTES = 8;
    localparam int ATR_BITS = 32;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 7'h6f;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] BYTE_FULL = 4'h8;
    localparam logic [3:0] SECTOR_LIMIT = 4'he;

    // ----------------------------------------
    // command encodings, msb first on the wire
    // ----------------------------------------
    localparam logic [7:0] CMD_SECTOR_MASK = 8'he0;
    localparam logic [7:0] CMD_SECTOR_CODE = 8'h80;
    localparam int CMD_SECTOR_LSB = 1;
    localparam int CMD_RW_BIT = 0;
    localparam logic [7:0] CMD_CHG_WRITE_PWD = 8'hfc;
    localparam logic [7:0] CMD_CHG_READ_PWD = 8'hfe;
    localparam logic [7:0] CMD_PWD_POLL = 8'h55;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [63:0] PWD_RESET = 64'h0000_0000_0000_0000;
    // arbitrary neutral value; the real pattern is fixed per product
    localparam logic [31:0] ATR_PATTERN_DEFAULT = 32'h0f0f_3c3c;

    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_PWD, ST_WDATA, ST_RDATA, ST_ATR} proto_state_t;
    typedef enum logic [2:0] {OP_NONE, OP_WRITE, OP_READ, OP_CHG_WPW, OP_CHG_RPW} pending_op_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] cs_s;
        logic [2:0] rst_s;
        proto_state_t state;
        proto_state_t after;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic ack;
        logic oe;
        pending_op_t op;
        logic [3:0] sector;
        logic pwd_ok;
        logic mism;
        logic [3:0] bytes;
        logic over;
        logic [ADDR_W-1:0] addr;
        logic [63:0] wbuf;
        logic [4:0] atr_idx;
        logic [BUSY_W-1:0] busy_cnt;
        logic [63:0] wpw;
        logic [63:0] rpw;
        logic [ARRAY_BYTES-1:0][7:0] mem;
    } core_state_t;

endpackage
